// >>> bscce_pkg.sv
// shared constants and types for the bit-skip/clear/call/watchdog-clear executor
package bscce_pkg;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned PC_W = 13;
  localparam int unsigned STK_DEPTH = 8;
  localparam int unsigned STK_PTR_W = 3;
  localparam int unsigned PRE_W = 16;
  localparam int unsigned POST_W = 8;
  localparam int unsigned OPC_W = 14;
  // opcode fields
  localparam int unsigned BIT_LSB = 7;
  localparam int unsigned CALL_K_W = 11;
  localparam int unsigned LATCH_HI = 4;
  localparam int unsigned LATCH_LO = 3;
  // opcode patterns
  localparam logic [3:0] OP_BIT_TEST_SKIP_IF_CLEAR_HI = 4'h6;
  localparam logic [3:0] OP_BIT_TEST_SKIP_IF_SET_HI = 4'h7;
  localparam logic [6:0] OP_CLEAR_FILE_REGISTER_OP_HI = 7'h03;
  localparam logic [6:0] OP_CLEAR_ACCUMULATOR_OP_HI = 7'h02;
  localparam logic [2:0] OP_CALL_HI = 3'h4;
  localparam logic [13:0] OP_WDCLR = 14'h0064;
  localparam logic [7:0] CLEAR_VAL = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  typedef enum logic [2:0] {
    BSCCE_NONE,
    BSCCE_SKIP_CLR,
    BSCCE_SKIP_SET,
    BSCCE_CLEAR_FILE_REGISTER_OP,
    BSCCE_CLEAR_ACCUMULATOR_OP,
    BSCCE_CALL,
    BSCCE_WDCLR
  } bscce_op_t;
endpackage : bscce_pkg

// >>> bscce_core.sv
// instruction executor for bit tests, clears, call and watchdog clear
`timescale 1ns/10ps
`default_nettype none
module bscce_core
  import bscce_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_cyc_en,
  input wire logic [OPC_W-1:0] i_instr,
  input wire logic i_instr_valid,
  input wire logic [7:0] i_file_rdata,
  input wire logic [4:0] i_pc_upper_latch,
  input wire logic i_osc_fail,
  input wire logic i_sleep_exit,
  input wire logic i_crystal_mode,
  input wire logic i_startup_done,
  input wire logic i_wdt_tick,
  input wire logic i_prescaler_assignment,
  output logic [FADDR_W-1:0] o_file_addr,
  output logic o_file_we,
  output logic [7:0] o_file_wdata,
  output logic [7:0] o_accum,
  output logic o_zero_flag,
  output logic o_timeout_flag,
  output logic o_power_down_flag,
  output logic [PC_W-1:0] o_pc,
  output logic [PC_W-1:0] o_stack_top,
  output logic [STK_PTR_W-1:0] o_stack_ptr,
  output logic o_flush,
  output logic [PRE_W-1:0] o_prescaler,
  output logic [POST_W-1:0] o_postscaler,
  output logic o_wdt_hold
);
  typedef struct packed {
    logic [FADDR_W-1:0] faddr;
    logic fwe;
    logic [7:0] accum;
    logic zero;
    logic timeout;
    logic pdown;
    logic [PC_W-1:0] pc;
    logic [STK_DEPTH-1:0][PC_W-1:0] stk;
    logic [STK_PTR_W-1:0] sp;
    logic flush;
    logic [PRE_W-1:0] pre;
    logic [POST_W-1:0] post;
    logic hold;
  } bscce_state_t;

  bscce_state_t st_ff;
  bscce_state_t nxt_st;
  bscce_op_t op;
  logic [2:0] bit_sel;
  logic tested_bit;
  logic scaler_clr;

  always_comb
  begin
    op = BSCCE_NONE;
    if (i_instr[13:10] == OP_BIT_TEST_SKIP_IF_CLEAR_HI)
    begin
      op = BSCCE_SKIP_CLR;
    end
    else if (i_instr[13:10] == OP_BIT_TEST_SKIP_IF_SET_HI)
    begin
      op = BSCCE_SKIP_SET;
    end
    else if (i_instr[13:7] == OP_CLEAR_FILE_REGISTER_OP_HI)
    begin
      op = BSCCE_CLEAR_FILE_REGISTER_OP;
    end
    else if (i_instr[13:7] == OP_CLEAR_ACCUMULATOR_OP_HI)
    begin
      op = BSCCE_CLEAR_ACCUMULATOR_OP;
    end
    else if (i_instr[13:11] == OP_CALL_HI)
    begin
      op = BSCCE_CALL;
    end
    else if (i_instr == OP_WDCLR)
    begin
      op = BSCCE_WDCLR;
    end
  end

  // address and bit index are taken whole, so any of 128 registers and 8 bits work
  assign bit_sel = i_instr[BIT_LSB+2:BIT_LSB];
  assign tested_bit = i_file_rdata[bit_sel];

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.fwe = 1'b0;
    scaler_clr = 1'b0;
    if (i_cyc_en)
    begin
      nxt_st.flush = 1'b0;
      nxt_st.faddr = i_instr[FADDR_W-1:0];
      // a flushed slot executes as a no-op: counter advances, nothing else
      if (st_ff.flush || !i_instr_valid)
      begin
        nxt_st.pc = st_ff.pc + (st_ff.flush ? PC_ONE : PC_RESET);
      end
      else
      begin
        nxt_st.pc = st_ff.pc + PC_ONE;
        case (op)
          BSCCE_SKIP_CLR:
          begin
            nxt_st.flush = !tested_bit;
          end
          BSCCE_SKIP_SET:
          begin
            nxt_st.flush = tested_bit;
          end
          BSCCE_CLEAR_FILE_REGISTER_OP:
          begin
            nxt_st.fwe = 1'b1;
            nxt_st.zero = 1'b1;
          end
          BSCCE_CLEAR_ACCUMULATOR_OP:
          begin
            nxt_st.accum = CLEAR_VAL;
            nxt_st.zero = 1'b1;
          end
          BSCCE_CALL:
          begin
            // the stack wraps after eight pushes; the oldest return address is lost
            nxt_st.stk[st_ff.sp] = st_ff.pc + PC_ONE;
            nxt_st.sp = st_ff.sp + 3'h1;
            nxt_st.pc = {i_pc_upper_latch[LATCH_HI:LATCH_LO],
                         i_instr[CALL_K_W-1:0]};
            nxt_st.flush = 1'b1;
          end
          BSCCE_WDCLR:
          begin
            scaler_clr = 1'b1;
            nxt_st.timeout = 1'b1;
            nxt_st.pdown = 1'b1;
          end
          default:
          begin
            nxt_st.flush = 1'b0;
          end
        endcase
      end
    end
    // crystal wake-up: the start-up count borrows the watchdog counter
    if (i_sleep_exit && i_crystal_mode)
    begin
      nxt_st.hold = 1'b1;
    end
    else if (st_ff.hold && i_startup_done)
    begin
      nxt_st.hold = 1'b0;
      scaler_clr = 1'b1;
    end
    if (i_osc_fail)
    begin
      scaler_clr = 1'b1;
    end
    // hold keeps the prescaler at zero, and the postscaler too when i_prescaler_assignment is set, so the start-up count owns the ripple chain
    if (scaler_clr || nxt_st.hold)
    begin
      nxt_st.pre = '0;
      nxt_st.post = i_prescaler_assignment ? '0 : st_ff.post;
    end
    else if (i_wdt_tick)
    begin
      nxt_st.pre = st_ff.pre + 16'h0001;
      if (st_ff.pre == '1)
      begin
        nxt_st.post = st_ff.post + 8'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_file_addr = st_ff.faddr;
  assign o_file_we = st_ff.fwe;
  assign o_file_wdata = CLEAR_VAL;
  assign o_accum = st_ff.accum;
  assign o_zero_flag = st_ff.zero;
  assign o_timeout_flag = st_ff.timeout;
  assign o_power_down_flag = st_ff.pdown;
  assign o_pc = st_ff.pc;
  // top of stack is the array flop picked by the pointer minus one, no copy is kept
  assign o_stack_top = st_ff.stk[st_ff.sp - 3'h1];
  assign o_stack_ptr = st_ff.sp;
  assign o_flush = st_ff.flush;
  assign o_prescaler = st_ff.pre;
  assign o_postscaler = st_ff.post;
  assign o_wdt_hold = st_ff.hold;
endmodule : bscce_core
`default_nettype wire

// >>> bscce_core_sva.sv
// executor assertions
`timescale 1ns/10ps
`default_nettype none
module bscce_chk
  import bscce_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_cyc_en,
  input wire logic i_instr_valid,
  input wire logic [OPC_W-1:0] i_instr,
  input wire logic o_flush,
  input wire logic o_zero_flag,
  input wire logic o_timeout_flag,
  input wire logic o_power_down_flag,
  input wire logic [PC_W-1:0] o_pc,
  input wire logic [PRE_W-1:0] o_prescaler
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic ex = i_cyc_en && i_instr_valid && !o_flush;
  wire logic wd = ex && i_instr == OP_WDCLR;
  wire logic ca = ex && i_instr[13:11] == OP_CALL_HI;
  wire logic sk = ex && i_instr[13:11] == 3'h3;
  chk_wd_flags: assert property (wd |=> o_timeout_flag && o_power_down_flag)
    else $error("wd flags");
  chk_wd_pre: assert property (wd |=> o_prescaler == '0)
    else $error("wd count");
  chk_clear_accumulator_op_zero: assert property (ex && i_instr[13:7] == OP_CLEAR_ACCUMULATOR_OP_HI |=> o_zero_flag)
    else $error("clear_accumulator_op");
  chk_clear_file_register_op_zero: assert property (ex && i_instr[13:7] == OP_CLEAR_FILE_REGISTER_OP_HI |=> o_zero_flag)
    else $error("clear_file_register_op");
  chk_call_pc: assert property (ca |=> o_flush && o_pc[10:0] == $past(i_instr[10:0]))
    else $error("call pc");
  chk_call_flags: assert property (ca |=> $stable({o_zero_flag, o_timeout_flag, o_power_down_flag}))
    else $error("call flags");
  chk_skip_flag: assert property (sk |=> $stable(o_zero_flag))
    else $error("skip flags");
  chk_slot_pc: assert property (i_cyc_en && i_instr_valid && o_flush |=>
    !o_flush && o_pc == $past(o_pc) + PC_ONE) else $error("slot pc");
endmodule : bscce_chk
bind bscce_core bscce_chk bscce_chk_i (.i_ref_clk, .i_rst_n, .i_cyc_en, .i_instr_valid,
  .i_instr, .o_flush, .o_zero_flag, .o_timeout_flag, .o_power_down_flag, .o_pc, .o_prescaler);
`default_nettype wire

// >>> tb_bit_skip_clear_call_exec.sv
// executor bench
`timescale 1ns/10ps
`default_nettype none
module tb_bit_skip_clear_call_exec;
  import bscce_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0;
  // c: cycle enable, osc fail, sleep exit, start-up done, tick
  logic [4:0] c = 5'h00;
  logic [13:0] ins = 14'h0000;
  logic [12:0] pc, top, e = 13'h0000;
  logic [15:0] pre;
  logic we, z, to, pd, fl, hold;
  logic [7:0] acc, post, fd;
  logic [6:0] fa;
  logic [2:0] sp;
  logic prescaler_assignment = 1'h1, xtal = 1'h1;
  int n_fail = 0, check_count = 0;
  always #5 clk = ~clk;
  bscce_core bscce_core_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cyc_en(c[4]), .i_instr(ins),
    .i_instr_valid(c[4]), .i_file_rdata(8'haa), .i_pc_upper_latch(5'h0f), .i_osc_fail(c[3]),
    .i_sleep_exit(c[2]), .i_crystal_mode(xtal), .i_startup_done(c[1]), .i_wdt_tick(c[0]),
    .i_prescaler_assignment(prescaler_assignment), .o_file_addr(fa), .o_file_we(we), .o_file_wdata(fd),
    .o_accum(acc), .o_zero_flag(z), .o_timeout_flag(to), .o_power_down_flag(pd), .o_pc(pc),
    .o_stack_top(top), .o_stack_ptr(sp), .o_flush(fl), .o_prescaler(pre), .o_postscaler(post),
    .o_wdt_hold(hold));
  task automatic chk(string n, logic [31:0] s, x);
    check_count++;
    if (s !== x)
    begin
      n_fail++;
      $display("FAIL %s exp %h got %h", n, x, s);
    end
  endtask : chk
  task automatic go(logic [4:0] v, int n = 1, logic [13:0] op = 14'h0000);
    @(posedge clk);
    c <= v;
    ins <= op;
    repeat (n) @(posedge clk);
    c <= 5'h00;
    #1;
    e += 13'(v[4]);
  endtask : go
  task automatic t_op();
    go(5'h10, 1, 14'h0100);
    chk("z", z, 1'h1);
    chk("acc", acc, 8'h00);
    go(5'h10, 1, 14'h01ff);
    chk("we", {we, to}, 2'h2);
    chk("faddr", {fa, fd}, 15'h7f00);
    // odd bits of the data are set, so i[0] is the tested bit value
    for (int i = 0; i < 4; i++)
    begin
      go(5'h10, 1, {3'h3, i[1], 3'(i * 2 + i[0]), 7'h7f});
      chk("skip", {fl, z}, {i[1] == i[0], 1'h1});
      go(5'h10);
      chk("pc", pc, e);
    end
    $display("t_op end");
  endtask : t_op
  task automatic t_call();
    go(5'h10, 1, 14'h27ff);
    chk("call", {top, pc, fl}, {e, 13'h0fff, 1'h1});
    chk("sp", sp, 3'h1);
    // a watchdog clear in the discarded slot must leave no trace
    go(5'h10, 1, OP_WDCLR);
    e = 13'h1000;
    chk("slot", {pc, to}, {e, 1'h0});
    $display("t_call end");
  endtask : t_call
  task automatic t_wdt();
    go(5'h01, 3);
    chk("pre", pre, 16'h0003);
    go(5'h10, 1, OP_WDCLR);
    chk("wd", {to, pd, pre}, 18'h30000);
    go(5'h01, 2);
    go(5'h08);
    chk("osc", pre, 16'h0000);
    go(5'h04);
    go(5'h01, 2);
    chk("ost", {hold, pre}, 17'h10000);
    go(5'h02);
    go(5'h01);
    chk("run", {hold, pre}, 17'h00001);
    $display("t_wdt end");
  endtask : t_wdt
  task automatic t_post();
    // the postscaler only moves on a prescaler wrap, so one full wrap is run
    go(5'h08);
    go(5'h01, 65536);
    chk("wrap", {post, pre}, 24'h010000);
    go(5'h01);
    @(posedge clk);
    prescaler_assignment <= 1'h0;
    go(5'h08);
    chk("psa0", {post, pre}, 24'h010000);
    @(posedge clk);
    prescaler_assignment <= 1'h1;
    go(5'h01);
    go(5'h10, 1, OP_WDCLR);
    chk("psa1", {post, pre}, 24'h000000);
    @(posedge clk);
    xtal <= 1'h0;
    go(5'h04);
    go(5'h01);
    chk("rc wake", {hold, pre}, 17'h00001);
    @(posedge clk);
    xtal <= 1'h1;
    $display("t_post end");
  endtask : t_post
  task automatic conclude();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    t_op();
    t_call();
    t_wdt();
    t_post();
    conclude();
  end
endmodule : tb_bit_skip_clear_call_exec
`default_nettype wire
